//--- logic/kmio_port_top.sv
`timescale 1ns/1ps
`include "kmio_defs.svh"
module kmio_port_top #(
    parameter bit FIXED_BIT_OUT = 1'b1,
    parameter bit CARRIER_HALF = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [3:0] keyReturnIn,
    input wire logic [3:0] portBIn,
    output logic [3:0] portBOut,
    output logic [3:0] portBOe,
    output logic [3:0] portBPullEn,
    input wire logic [3:0] portCIn,
    output logic [3:0] portCOut,
    output logic [3:0] portCOe,
    output logic [3:0] portCPullEn,
    input wire logic [3:0] portDIn,
    output logic [3:0] portDOut,
    output logic [3:0] portDOe,
    output logic [3:0] portDPullEn,
    input wire logic [3:0] portEIn,
    output logic [3:0] portEOut,
    output logic [3:0] portEOe,
    output logic [3:0] portEPullEn,
    input wire logic fixedBitIn,
    output logic fixedBitOut,
    output logic fixedBitOe,
    output logic irTransmitOutput,
    input wire logic extIntIn,
    output logic irqToCpu,
    input wire logic extResetN,
    input wire logic powerOnClear,
    input wire logic wdtOverflow,
    output logic standby,
    output logic carrierClkEn,
    output logic irq
);
    import kmio_pkg::*;

    kmio_state_t s_q;
    kmio_state_t s_d;
    logic [`KMIO_SYNC_W-1:0] syncd;
    logic [3:0] aS, bS, cS, dS, eS;
    logic fixS, intS, resetNS, porS;
    logic chipReset;
    logic [3:0] keyLowB, keyLowC, keyLowD;
    logic keyAny;
    logic wakeCond;

    // every pin input passes two flops before use
    kmio_sync #(
        .W(`KMIO_SYNC_W),
        .RST_VAL(`KMIO_SYNC_RST)
    ) pinSync (
        .core_clk(core_clk),
        .rst(rst),
        .asyncIn({powerOnClear, extResetN, extIntIn, fixedBitIn, portEIn,
                  portDIn, portCIn, portBIn, keyReturnIn}),
        .syncOut(syncd)
    );

    assign aS = syncd[3:0];
    assign bS = syncd[7:4];
    assign cS = syncd[11:8];
    assign dS = syncd[15:12];
    assign eS = syncd[19:16];
    assign fixS = syncd[20];
    assign intS = syncd[21];
    assign resetNS = syncd[22];
    assign porS = syncd[23];

    // watchdog is on our clock, so it needs no synchroniser
    assign chipReset = rst | wdtOverflow | porS | ~resetNS;

    // key sense counts only lines that are in input direction
    assign keyLowB = ~bS & ~s_q.dirB;
    assign keyLowC = ~cS & {4{~s_q.dirC}};
    assign keyLowD = ~dS & {4{~s_q.dirD}};
    assign keyAny = (|(~aS)) | (|keyLowB) | (|keyLowC) | (|keyLowD);
    // interrupt wakes even without permission
    assign wakeCond = keyAny | intS;

    // readback of one register; bit 32 flags a mapped address
    function automatic logic [32:0] regRead(input logic [7:0] a);
        logic [32:0] v;
        v = {1'b1, 32'h0};
        case (a)
            `KMIO_OFF_CTRL: begin
                v[`KMIO_CTRL_DIRC] = s_q.dirC;
                v[`KMIO_CTRL_DIRD] = s_q.dirD;
                v[`KMIO_CTRL_PERM] = s_q.irqPerm;
                v[`KMIO_CTRL_STBY] = (s_q.mode == KMIO_STANDBY);
            end
            `KMIO_OFF_BDIR: v[3:0] = s_q.dirB;
            `KMIO_OFF_EDIR: v[3:0] = s_q.dirE;
            `KMIO_OFF_EPULL: v[3:0] = s_q.pullE;
            `KMIO_OFF_OUT: begin
                v[`KMIO_OUT_B +: 4] = s_q.outB;
                v[`KMIO_OUT_C +: 4] = s_q.outC;
                v[`KMIO_OUT_D +: 4] = s_q.outD;
                v[`KMIO_OUT_E +: 4] = s_q.outE;
                v[`KMIO_OUT_FIX] = s_q.outFix;
                v[`KMIO_OUT_IRTX] = s_q.irTx;
            end
            `KMIO_OFF_IN: begin
                v[`KMIO_IN_A +: 4] = aS;
                v[`KMIO_IN_B +: 4] = bS;
                v[`KMIO_IN_C +: 4] = cS;
                v[`KMIO_IN_D +: 4] = dS;
                v[`KMIO_IN_E +: 4] = eS;
                v[`KMIO_IN_FIX] = fixS;
                v[`KMIO_IN_INT] = intS;
            end
            `KMIO_OFF_STAT: v[`KMIO_ST_W-1:0] = s_q.status;
            `KMIO_OFF_MASK: v[`KMIO_ST_W-1:0] = s_q.mask;
            `KMIO_OFF_INFO: begin
                v[`KMIO_INFO_FIXOUT] = FIXED_BIT_OUT;
                v[`KMIO_INFO_HALF] = CARRIER_HALF;
            end
            default: v = 33'h0;
        endcase
        return v;
    endfunction

    // bus slave, port control, events and reset in one next-state block
    always_comb begin
        logic [32:0] rd;
        logic [32:0] cur;
        logic [31:0] bm;
        logic [31:0] nw;
        logic [2:0] clrStat;
        logic [2:0] setStat;
        logic goStandby;
        s_d = s_q;
        rd = 33'h0;
        cur = 33'h0;
        bm = 32'h0;
        nw = 32'h0;
        clrStat = 3'h0;
        setStat = 3'h0;
        goStandby = 1'b0;
        if (awvalid && awready) begin
            s_d.awHave = 1'b1;
            s_d.awAddr = awaddr;
        end
        if (wvalid && wready) begin
            s_d.wHave = 1'b1;
            s_d.wData = wdata;
            s_d.wStrb = wstrb;
        end
        if (bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        if (rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        // a status read clears what it returned
        if (arvalid && arready) begin
            rd = regRead(araddr);
            s_d.rvalid = 1'b1;
            s_d.rdata = rd[31:0];
            s_d.rresp = rd[32] ? `KMIO_RESP_OKAY : `KMIO_RESP_SLVERR;
            if (araddr == `KMIO_OFF_STAT) begin
                clrStat = rd[`KMIO_ST_W-1:0];
            end
        end
        // write once both halves are held; strobes merge per byte
        if (s_q.awHave && s_q.wHave && !s_q.bvalid) begin
            cur = regRead(s_q.awAddr);
            bm = {{8{s_q.wStrb[3]}}, {8{s_q.wStrb[2]}},
                  {8{s_q.wStrb[1]}}, {8{s_q.wStrb[0]}}};
            nw = (cur[31:0] & ~bm) | (s_q.wData & bm);
            s_d.awHave = 1'b0;
            s_d.wHave = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = cur[32] ? `KMIO_RESP_OKAY : `KMIO_RESP_SLVERR;
            case (s_q.awAddr)
                `KMIO_OFF_CTRL: begin
                    s_d.dirC = nw[`KMIO_CTRL_DIRC];
                    s_d.dirD = nw[`KMIO_CTRL_DIRD];
                    s_d.irqPerm = nw[`KMIO_CTRL_PERM];
                    goStandby = nw[`KMIO_CTRL_STBY] & s_q.wStrb[0];
                end
                `KMIO_OFF_BDIR: s_d.dirB = nw[3:0];
                `KMIO_OFF_EDIR: s_d.dirE = nw[3:0];
                `KMIO_OFF_EPULL: s_d.pullE = nw[3:0];
                `KMIO_OFF_OUT: begin
                    s_d.outB = nw[`KMIO_OUT_B +: 4];
                    s_d.outC = nw[`KMIO_OUT_C +: 4];
                    s_d.outD = nw[`KMIO_OUT_D +: 4];
                    s_d.outE = nw[`KMIO_OUT_E +: 4];
                    s_d.outFix = nw[`KMIO_OUT_FIX];
                    s_d.irTx = nw[`KMIO_OUT_IRTX];
                end
                `KMIO_OFF_MASK: s_d.mask = nw[`KMIO_ST_W-1:0];
                default: ;
            endcase
        end
        // standby: a pending wake keeps the core running
        case (s_q.mode)
            KMIO_RUN: begin
                if (goStandby && !wakeCond) begin
                    s_d.mode = KMIO_STANDBY;
                end
            end
            KMIO_STANDBY: begin
                if (wakeCond) begin
                    s_d.mode = KMIO_RUN;
                    setStat[`KMIO_ST_WAKE] = 1'b1;
                end
            end
            default: s_d.mode = KMIO_RUN;
        endcase
        setStat[`KMIO_ST_INT] = intS & ~s_q.intPrev;
        setStat[`KMIO_ST_KEY] = keyAny & ~s_q.keyPrev;
        s_d.intPrev = intS;
        s_d.keyPrev = keyAny;
        // set beats a clear that lands in the same cycle
        s_d.status = (s_q.status & ~clrStat) | setStat;
        s_d.carrierPh = ~s_q.carrierPh;
        // any reset source restores the pin side; only rst also clears the bus side
        if (chipReset) begin
            s_d.mode = KMIO_RUN;
            s_d.dirC = `KMIO_RST_DIRCD;
            s_d.dirD = `KMIO_RST_DIRCD;
            s_d.irqPerm = 1'b0;
            s_d.dirB = `KMIO_RST_DIR4;
            s_d.dirE = `KMIO_RST_DIR4;
            s_d.pullE = `KMIO_RST_DIR4;
            s_d.outB = `KMIO_RST_OUT4;
            s_d.outC = `KMIO_RST_OUT4;
            s_d.outD = `KMIO_RST_OUT4;
            s_d.outE = `KMIO_RST_OUT4;
            s_d.outFix = `KMIO_RST_FIX;
            s_d.irTx = `KMIO_RST_IRTX;
            s_d.status = 3'h0;
            s_d.mask = `KMIO_RST_MASK;
            s_d.intPrev = 1'b0;
            s_d.keyPrev = 1'b0;
            s_d.carrierPh = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.mode <= KMIO_RUN;
            s_q.dirC <= `KMIO_RST_DIRCD;
            s_q.dirD <= `KMIO_RST_DIRCD;
            s_q.outFix <= `KMIO_RST_FIX;
        end else begin
            s_q <= s_d;
        end
    end

    // bus handshakes: one write and one read in flight
    assign awready = ~s_q.awHave & ~s_q.bvalid;
    assign wready = ~s_q.wHave & ~s_q.bvalid;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = ~s_q.rvalid;
    assign rvalid = s_q.rvalid;
    assign rdata = s_q.rdata;
    assign rresp = s_q.rresp;

    // open-drain groups never drive high; pull-ups only in input direction
    assign portBOut = 4'h0;
    assign portBOe = s_q.dirB & ~s_q.outB;
    assign portBPullEn = ~s_q.dirB;
    assign portCOut = 4'h0;
    assign portCOe = {4{s_q.dirC}} & ~s_q.outC;
    assign portCPullEn = {4{~s_q.dirC}};
    assign portDOut = 4'h0;
    assign portDOe = {4{s_q.dirD}} & ~s_q.outD;
    assign portDPullEn = {4{~s_q.dirD}};

    // push-pull group: pull-up only matters while a line is an input
    assign portEOut = s_q.outE;
    assign portEOe = s_q.dirE;
    assign portEPullEn = ~s_q.dirE & s_q.pullE;

    // variant strap: output variants pull low, input variants never drive
    assign fixedBitOut = 1'b0;
    assign fixedBitOe = FIXED_BIT_OUT & ~s_q.outFix;

    assign irTransmitOutput = s_q.irTx;
    assign irqToCpu = intS & s_q.irqPerm;
    assign standby = (s_q.mode == KMIO_STANDBY);
    // half-rate variants get an enable on every other cycle
    assign carrierClkEn = CARRIER_HALF ? s_q.carrierPh : 1'b1;
    assign irq = |(s_q.status & s_q.mask);

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    grpc_dir_a: assert property (
        (portCPullEn == 4'h0) || (portCPullEn == 4'hf))
        else $error("port C pull-ups split across lines");
    portb_bit_a: assert property (
        ((portBOe & ~s_q.dirB) == 4'h0) && (portBPullEn == ~s_q.dirB))
        else $error("port B line driven while in input direction");
    od_low_a: assert property (
        (portBOut | portCOut | portDOut) == 4'h0)
        else $error("open-drain group drove high");
    keyret_wake_a: assert property (
        (standby && !chipReset && (|{keyLowB, keyLowC, keyLowD}))
        |=> !standby)
        else $error("key-return low did not end standby");
    dedic_wake_a: assert property (
        (standby && !chipReset && (aS != 4'hf)) |=> !standby)
        else $error("dedicated input low did not end standby");
    int_wake_a: assert property (
        (standby && intS && !s_q.irqPerm) |=> !standby)
        else $error("interrupt without permission kept standby");
    irq_gate_a: assert property (
        irqToCpu |-> (s_q.irqPerm && syncd[21]))
        else $error("interrupt passed without permission");
    wdt_reset_a: assert property (
        wdtOverflow |=> (!irTransmitOutput && portCOe == 4'hf
                         && portBOe == 4'h0 && !standby))
        else $error("watchdog overflow did not reset the ports");
    pp_drive_a: assert property (
        $rose(s_q.dirE[0]) |-> (portEOe[0] && portEOut[0] == s_q.outE[0]))
        else $error("push-pull line not driven in output direction");
    pull_sel_a: assert property (
        s_q.dirE[1] |-> !portEPullEn[1])
        else $error("pull-up left on a push-pull output");
    fixbit_a: assert property (
        fixedBitOe |-> FIXED_BIT_OUT)
        else $error("input variant drove the fixed bit");
    carrier_a: assert property (
        (CARRIER_HALF && carrierClkEn && !chipReset) |=> !carrierClkEn)
        else $error("half-rate carrier enable on adjacent cycles");
    rst_vals_a: assert property (
        $past(chipReset) |-> (!irTransmitOutput && portCOe == 4'hf
                              && portDOe == 4'hf && portEOe == 4'h0))
        else $error("reset values of ports wrong");
    // one edge latches both halves, the next applies and raises bvalid
    wresp_time_a: assert property (
        (awvalid && awready && wvalid && wready) |-> ##2 bvalid)
        else $error("write response not raised two edges after taking");

    wake_c: cover property (standby ##1 !standby);
    wr_c: cover property (bvalid && bready);
    rd_c: cover property (rvalid && rready && rresp == `KMIO_RESP_OKAY);
    irq_c: cover property (irq && irqToCpu);
endmodule

//--- logic/kmio_defs.svh
// Contract
// - port C direction switches all four lines together only.
// - each port B line has its own direction bit.
// - key-return groups in input direction get pull-ups and sense keys.
// - a low on any input-direction key-return line ends standby.
// - key-matrix groups in output direction only pull low.
// - dedicated input group is key-return; any low line ends standby.
// - push-pull group lines in output direction are driven both ways.
// - push-pull group pull-ups are chosen per line in input direction.
// - active external interrupt ends standby regardless of permission.
// - external interrupt reaches the processor only while permitted.
// - reset comes from reset pin, power-on clear or watchdog overflow.
// - transmit output is active high and push-pull.
// - single-bit port is fixed open-drain output or input per variant.
// - carrier clock is half or full oscillator rate per variant.
`ifndef KMIO_DEFS_SVH
`define KMIO_DEFS_SVH

`define KMIO_ADDR_W 8
// register offsets
`define KMIO_OFF_CTRL 8'h00
`define KMIO_OFF_BDIR 8'h04
`define KMIO_OFF_EDIR 8'h08
`define KMIO_OFF_EPULL 8'h0c
`define KMIO_OFF_OUT 8'h10
`define KMIO_OFF_IN 8'h14
`define KMIO_OFF_STAT 8'h18
`define KMIO_OFF_MASK 8'h1c
`define KMIO_OFF_INFO 8'h20
// control fields
`define KMIO_CTRL_DIRC 0
`define KMIO_CTRL_DIRD 1
`define KMIO_CTRL_PERM 2
`define KMIO_CTRL_STBY 3
// status and mask fields
`define KMIO_ST_W 3
`define KMIO_ST_WAKE 0
`define KMIO_ST_INT 1
`define KMIO_ST_KEY 2
// output register fields
`define KMIO_OUT_B 0
`define KMIO_OUT_C 4
`define KMIO_OUT_D 8
`define KMIO_OUT_E 12
`define KMIO_OUT_FIX 16
`define KMIO_OUT_IRTX 17
// input register fields
`define KMIO_IN_A 0
`define KMIO_IN_B 4
`define KMIO_IN_C 8
`define KMIO_IN_D 12
`define KMIO_IN_E 16
`define KMIO_IN_FIX 20
`define KMIO_IN_INT 21
// info fields
`define KMIO_INFO_FIXOUT 0
`define KMIO_INFO_HALF 1
// reset values
`define KMIO_RST_DIRCD 1'h1
`define KMIO_RST_DIR4 4'h0
`define KMIO_RST_OUT4 4'h0
`define KMIO_RST_FIX 1'h1
`define KMIO_RST_IRTX 1'h0
`define KMIO_RST_MASK 3'h0
// pin synchroniser: width and idle levels
`define KMIO_SYNC_W 24
`define KMIO_SYNC_RST 24'h5fffff
// bus responses
`define KMIO_RESP_OKAY 2'h0
`define KMIO_RESP_SLVERR 2'h2

`endif

//--- logic/kmio_pkg.sv
package kmio_pkg;

    typedef enum logic {
        KMIO_RUN,
        KMIO_STANDBY
    } kmio_mode_t;

    typedef struct packed {
        kmio_mode_t mode;
        logic dirC;
        logic dirD;
        logic irqPerm;
        logic [3:0] dirB;
        logic [3:0] dirE;
        logic [3:0] pullE;
        logic [3:0] outB;
        logic [3:0] outC;
        logic [3:0] outD;
        logic [3:0] outE;
        logic outFix;
        logic irTx;
        logic [2:0] status;
        logic [2:0] mask;
        logic intPrev;
        logic keyPrev;
        logic carrierPh;
        logic awHave;
        logic wHave;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } kmio_state_t;

endpackage

//--- logic/kmio_sync.sv
`timescale 1ns/1ps
module kmio_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } kmio_sync_t;

    kmio_sync_t s_q;
    kmio_sync_t s_d;

    // first stage only feeds the second, nothing else looks at it
    always_comb begin
        s_d = s_q;
        s_d.meta = asyncIn;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= {RST_VAL, RST_VAL};
        end else begin
            s_q <= s_d;
        end
    end

    assign syncOut = s_q.stable;
endmodule

//--- tb/kmio_key_model.sv
`timescale 1ns/1ps
module kmio_key_model (
    input wire logic core_clk,
    input wire logic [3:0] bOe,
    input wire logic [3:0] bPull,
    input wire logic [3:0] cOe,
    input wire logic [3:0] cPull,
    input wire logic [3:0] eOe,
    input wire logic [3:0] eOut,
    input wire logic [3:0] ePull,
    input wire logic [3:0] pressB,
    input wire logic [3:0] pressC,
    output logic [3:0] bPin,
    output logic [3:0] cPin,
    output logic [3:0] ePin
);
    logic [3:0] drift = 4'h5;
    // released lines without pull-up wander so no stale level is read
    always @(posedge core_clk) drift <= ~drift;
    // a pressed key ties its return line low through the matrix
    assign bPin = ~bOe & ~pressB & (bPull | drift);
    assign cPin = ~cOe & ~pressC & (cPull | drift);
    // push-pull lines follow the device whenever it drives them
    assign ePin = (eOe & eOut) | (~eOe & (ePull | drift));
endmodule

//--- tb/kmio_port_top_tb_top.sv
`timescale 1ns/1ps
`include "kmio_defs.svh"
module kmio_port_top_tb_top;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rv;
    logic [3:0] keyReturnIn = 4'hf, pressB = 4'h0, pressC = 4'h0;
    logic extIntIn = 1'b0, extResetN = 1'b1;
    logic powerOnClear = 1'b0, wdtOverflow = 1'b0;
    logic [3:0] bPin, cPin, ePin, portBOut, portBOe, portBPullEn;
    logic [3:0] portCOut, portCOe, portCPullEn, portDOut, portDOe;
    logic [3:0] portDPullEn, portEOut, portEOe, portEPullEn;
    logic fixedBitOut, fixedBitOe, irTransmitOutput, irqToCpu;
    logic standby, carrierClkEn, irq;
    int failCount = 0;
    int testsRun = 0;

    initial forever #25 core_clk = ~core_clk;

    // open-drain port D and the single bit read back high when released
    kmio_port_top uut (.core_clk(core_clk), .rst(rst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .keyReturnIn(keyReturnIn), .portBIn(bPin),
        .portBOut(portBOut), .portBOe(portBOe), .portBPullEn(portBPullEn),
        .portCIn(cPin), .portCOut(portCOut), .portCOe(portCOe),
        .portCPullEn(portCPullEn), .portDIn(~portDOe), .portDOut(portDOut),
        .portDOe(portDOe), .portDPullEn(portDPullEn), .portEIn(ePin),
        .portEOut(portEOut), .portEOe(portEOe), .portEPullEn(portEPullEn),
        .fixedBitIn(~fixedBitOe), .fixedBitOut(fixedBitOut),
        .fixedBitOe(fixedBitOe), .irTransmitOutput(irTransmitOutput),
        .extIntIn(extIntIn), .irqToCpu(irqToCpu), .extResetN(extResetN),
        .powerOnClear(powerOnClear), .wdtOverflow(wdtOverflow),
        .standby(standby), .carrierClkEn(carrierClkEn), .irq(irq));

    kmio_key_model keys (.core_clk(core_clk), .bOe(portBOe),
        .bPull(portBPullEn), .cOe(portCOe), .cPull(portCPullEn),
        .eOe(portEOe), .eOut(portEOut), .ePull(portEPullEn),
        .pressB(pressB), .pressC(pressC), .bPin(bPin), .cPin(cPin),
        .ePin(ePin));

    task endSim;
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        testsRun++;
        if (g !== e) begin
            failCount++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // a bus answer that never comes ends the run
    task tmo(input int n);
        if (n >= 200) begin
            failCount++;
            $display("mismatch bus answer expected 1 seen 0");
            endSim;
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic aw, w;
        n = 0;
        aw = 1'b1;
        w = 1'b1;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // each half is released on its own handshake edge
        while ((aw || w) && n < 200) begin
            @(posedge core_clk);
            n++;
            if (aw && awready) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (bvalid !== 1'b1 && n < 200);
        r = bresp;
        bready <= 1'b0;
        tmo(n);
    endtask

    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (arready !== 1'b1 && n < 200);
        arvalid <= 1'b0;
        do begin
            @(posedge core_clk);
            n++;
        end while (rvalid !== 1'b1 && n < 200);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        tmo(n);
    endtask

    // wake goes through a two-flop synchroniser, so allow a few edges
    task waitStby(input logic e);
        int n;
        n = 0;
        while (standby !== e && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        chk("standby", {31'h0, e}, {31'h0, standby});
    endtask

    task tReset;
        chk("portCOe", 32'hf, portCOe);
        chk("portDOe", 32'hf, portDOe);
        chk("portBOe", 32'h0, portBOe);
        chk("portEOe", 32'h0, portEOe);
        chk("irOut", 32'h0, irTransmitOutput);
        chk("fixedBitOe", 32'h0, fixedBitOe);
        rd(`KMIO_OFF_INFO, rv, resp);
        chk("info", 32'h3, rv);
        wr(`KMIO_OFF_OUT, 32'h0, resp);
        chk("fixedBitOe", 32'h1, fixedBitOe);
        chk("fixedBitOut", 32'h0, fixedBitOut);
        $display("test reset done");
    endtask

    task tGroups;
        wr(`KMIO_OFF_CTRL, 32'h0, resp);
        chk("portCOe", 32'h0, portCOe);
        chk("portCPullEn", 32'hf, portCPullEn);
        chk("portDOe", 32'h0, portDOe);
        chk("portDPullEn", 32'hf, portDPullEn);
        wr(`KMIO_OFF_CTRL, 32'h3, resp);
        wr(`KMIO_OFF_OUT, 32'h50, resp);
        chk("portCOe", 32'ha, portCOe);
        chk("portCOut", 32'h0, portCOut);
        chk("portDOut", 32'h0, portDOut);
        // key on line 3 settles through the synchroniser during the write
        pressB <= 4'h8;
        wr(`KMIO_OFF_BDIR, 32'h6, resp);
        chk("portBOe", 32'h6, portBOe);
        chk("portBPullEn", 32'h9, portBPullEn);
        chk("portBOut", 32'h0, portBOut);
        rd(`KMIO_OFF_IN, rv, resp);
        chk("inB", 32'h1, (rv >> 4) & 32'h9);
        pressB <= 4'h0;
        chk("inA", 32'hf, rv & 32'hf);
        $display("test groups done");
    endtask

    task tPushPull;
        wr(`KMIO_OFF_EDIR, 32'h3, resp);
        wr(`KMIO_OFF_EPULL, 32'hc, resp);
        wr(`KMIO_OFF_OUT, 32'ha000, resp);
        chk("portEOe", 32'h3, portEOe);
        chk("portEOut", 32'h2, portEOut & 4'h3);
        chk("portEPullEn", 32'hc, portEPullEn);
        rd(`KMIO_OFF_IN, rv, resp);
        chk("inE", 32'he, (rv >> 16) & 32'hf);
        $display("test push-pull done");
    endtask

    task tKeyWake;
        // turn port C to input first: stale synced lows would wake at once
        wr(`KMIO_OFF_CTRL, 32'h2, resp);
        repeat (4) @(posedge core_clk);
        rd(`KMIO_OFF_STAT, rv, resp);
        wr(`KMIO_OFF_CTRL, 32'ha, resp);
        chk("standby", 32'h1, standby);
        pressC <= 4'h4;
        waitStby(1'b0);
        pressC <= 4'h0;
        repeat (4) @(posedge core_clk);
        wr(`KMIO_OFF_CTRL, 32'hb, resp);
        chk("standby", 32'h1, standby);
        keyReturnIn <= 4'he;
        waitStby(1'b0);
        keyReturnIn <= 4'hf;
        repeat (4) @(posedge core_clk);
        rd(`KMIO_OFF_STAT, rv, resp);
        chk("status", 32'h5, rv);
        $display("test key wake done");
    endtask

    task tIntWake;
        wr(`KMIO_OFF_MASK, 32'h2, resp);
        wr(`KMIO_OFF_CTRL, 32'hb, resp);
        chk("standby", 32'h1, standby);
        extIntIn <= 1'b1;
        waitStby(1'b0);
        chk("irqToCpu", 32'h0, irqToCpu);
        wr(`KMIO_OFF_CTRL, 32'h7, resp);
        chk("irqToCpu", 32'h1, irqToCpu);
        chk("irq", 32'h1, irq);
        rd(`KMIO_OFF_STAT, rv, resp);
        chk("status", 32'h3, rv);
        chk("irq", 32'h0, irq);
        extIntIn <= 1'b0;
        wr(`KMIO_OFF_CTRL, 32'h3, resp);
        $display("test interrupt wake done");
    endtask

    // every reset source must bring the pins back to their idle state
    task tResetSrc;
        for (int i = 0; i < 3; i++) begin
            wr(`KMIO_OFF_OUT, 32'h200f0, resp);
            chk("irOut", 32'h1, irTransmitOutput);
            chk("portCOe", 32'h0, portCOe);
            wdtOverflow <= (i == 0);
            powerOnClear <= (i == 1);
            extResetN <= (i != 2);
            repeat (3) @(posedge core_clk);
            wdtOverflow <= 1'b0;
            powerOnClear <= 1'b0;
            extResetN <= 1'b1;
            repeat (6) @(posedge core_clk);
            chk("irOut", 32'h0, irTransmitOutput);
            chk("portCOe", 32'hf, portCOe);
        end
        $display("test reset sources done");
    endtask

    task tBusCarrier;
        int n;
        rd(8'h40, rv, resp);
        chk("rresp", `KMIO_RESP_SLVERR, resp);
        chk("rdata", 32'h0, rv);
        wr(8'h44, 32'h1, resp);
        chk("bresp", `KMIO_RESP_SLVERR, resp);
        wr(`KMIO_OFF_INFO, 32'h0, resp);
        chk("bresp", `KMIO_RESP_OKAY, resp);
        rd(`KMIO_OFF_INFO, rv, resp);
        chk("info", 32'h3, rv);
        n = 0;
        repeat (8) begin
            @(posedge core_clk);
            if (carrierClkEn === 1'b1) n++;
        end
        chk("carrier", 32'h4, n);
        $display("test bus and carrier done");
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        tReset;
        tGroups;
        tPushPull;
        tKeyWake;
        tIntWake;
        tResetSrc;
        tBusCarrier;
        endSim;
    end
endmodule
